// ===== hw/converter_mode_test_config_regs.v
// Purpose: Staged/active mode, stabilizer and test-output registers
// Assumes: Serial framing decoded elsewhere into addr/data/write strobe
// Notes:   Per-channel test settings steered by device-index bits
`include "converter_mode_test_config_regs.vh"

// Functional notes
// R1: Commit bit copies staged values to active
// R2: Update register resets to zero
// R3: Power mode 000 is run, reset value
// R4: 001 power-down, 010 standby
// R5: 011 reset, 100 continuous wave operation
// R6: Mode global; bits above field read zero
// R7: Stabilizer bit 0, resets enabled, global
// R8: User test mode two-bit encoding
// R9: Long generator reset bit holds generator
// R10: Short generator reset bit holds generator
// R11: Pattern codes 0000 through 0100
// R12: Pattern codes 0101 through 1000
// R13: Pattern codes 1001, 1011, 1100
// R14: Selected pattern replaces converter data output
// R15: Test settings per channel, generators global
// R16: Local writes only to indexed channels
// R17: Commit bit clears itself after copy
// R18: Host stages settings before commit
module converter_mode_test_config_regs
(
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_nrst,
    // Register access from serial port decoder
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    output reg  [7:0]  o_rdata,
    // Active global settings
    output reg  [2:0]  o_power_mode,
    output wire        o_chip_run,
    output wire        o_powered_down,
    output wire        o_standby,
    output wire        o_soft_reset,
    output wire        o_continuous_wave_operation,
    output wire        o_time_gain_signal_path_off,
    output reg         o_duty_cycle_stabilizer,
    output reg         o_long_pseudo_random_generator_rst,
    output reg         o_short_pseudo_random_generator_rst,
    // Active per-channel test settings
    output reg  [31:0] o_test_pattern,
    output reg  [15:0] o_user_test_mode,
    output wire [7:0]  o_test_active
);

    // Staged copies
    reg  [2:0]  mode_q;
    reg         dcs_q;
    reg  [3:0]  idx_lo_q;
    reg  [3:0]  idx_hi_q;
    reg  [31:0] pat_q;
    reg  [15:0] utm_q;
    reg         lrst_q;
    reg         srst_q;
    reg         commit_q;
    // Next values, write decodes, readback
    wire [31:0] pat_d;
    wire [15:0] utm_d;
    wire [7:0]  chan_sel;
    wire        commit_wr;
    wire        wr_mode;
    wire        wr_clock;
    wire        wr_test;
    wire        wr_idx_hi;
    wire        wr_idx_lo;
    reg  [2:0]  rd_ch;
    reg  [7:0]  rdata_d;
    integer     k;

    function is_addr;
        input [7:0] a;
        input [7:0] ofs;
        begin
            is_addr = (a == ofs);
        end
    endfunction

    // Exact match of one three-bit mode code
    function is_mode;
        input [2:0] m;
        input [2:0] code;
        begin
            is_mode = (m == code);
        end
    endfunction

    assign chan_sel  = {idx_hi_q, idx_lo_q};
    assign wr_mode   = i_wr && is_addr(i_addr, `OFS_POWER_MODE_CONTROL);
    assign wr_clock  = i_wr && is_addr(i_addr, `OFS_CLOCK_STABILIZER_CONTROL);
    assign wr_test   = i_wr && is_addr(i_addr, `OFS_TEST_OUTPUT_CONTROL);
    assign wr_idx_hi = i_wr && is_addr(i_addr, `OFS_DEVICE_INDEX_2);
    assign wr_idx_lo = i_wr && is_addr(i_addr, `OFS_DEVICE_INDEX_1);
    assign commit_wr = i_wr && is_addr(i_addr, `OFS_STAGED_SETTINGS_UPDATE) && i_wdata[0];

    // Staged power mode, global to all channels
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            mode_q <= `PM_RUN;                                     // R3
        end
        else if (wr_mode)
        begin
            // Bits 7:3 are dropped, so they always read back as zero
            mode_q <= i_wdata[2:0];                                // R6
        end
    end

    // Stabilizer enable, global; comes out of reset on
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            dcs_q <= 1'b1;                                         // R7
        end
        else if (wr_clock)
        begin
            dcs_q <= i_wdata[0];                                   // R7
        end
    end

    // Generator resets are chip-wide, so index bits do not gate them
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            lrst_q <= 1'b0;                                        // R9
            srst_q <= 1'b0;                                        // R10
        end
        else if (wr_test)
        begin
            lrst_q <= i_wdata[`TEST_LONG_PRN_RST_BIT];             // R15
            srst_q <= i_wdata[`TEST_SHORT_PRN_RST_BIT];
        end
    end

    // Channel index, all channels selected after reset
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            idx_hi_q <= `RST_DEVICE_INDEX;
            idx_lo_q <= `RST_DEVICE_INDEX;
        end
        else
        begin
            if (wr_idx_hi)
            begin
                idx_hi_q <= i_wdata[3:0];
            end
            if (wr_idx_lo)
            begin
                idx_lo_q <= i_wdata[3:0];
            end
        end
    end

    // Commit flag lives one cycle: copy happens, then it clears
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            commit_q <= 1'b0;                                      // R2
        end
        else
        begin
            commit_q <= commit_wr;                                 // R17
        end
    end

    // Per-channel next values; one driver per bit keeps channels apart
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1)
        begin : g_chan
            assign pat_d[ch*4 +: 4] = (wr_test && chan_sel[ch])                   // R16
                                    ? i_wdata[`TEST_PATTERN_MSB:`TEST_PATTERN_LSB]
                                    : pat_q[ch*4 +: 4];
            assign utm_d[ch*2 +: 2] = (wr_test && chan_sel[ch])
                                    ? i_wdata[`TEST_USER_MODE_MSB:`TEST_USER_MODE_LSB]
                                    : utm_q[ch*2 +: 2];
            // Any nonzero code replaces converter samples
            assign o_test_active[ch] = (o_test_pattern[ch*4 +: 4] != `TP_OFF); // R14
        end
    endgenerate

    // Staged per-channel settings
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            pat_q <= {`NUM_CHANNELS{`TP_OFF}};                     // R11
            utm_q <= 16'h0000;                                     // R8
        end
        else
        begin
            pat_q <= pat_d;
            utm_q <= utm_d;
        end
    end

    // Active per-channel copy moves only on commit
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_test_pattern   <= {`NUM_CHANNELS{`TP_OFF}};
            o_user_test_mode <= 16'h0000;
        end
        else if (commit_q)                                         // R1
        begin
            o_test_pattern   <= pat_q;                             // R12 R13
            o_user_test_mode <= utm_q;                             // R8
        end
    end

    // Active global copy
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_power_mode                        <= `PM_RUN;
            o_duty_cycle_stabilizer             <= 1'b1;
            o_long_pseudo_random_generator_rst  <= 1'b0;
            o_short_pseudo_random_generator_rst <= 1'b0;
        end
        else if (commit_q)                                         // R1
        begin
            o_power_mode                        <= mode_q;
            o_duty_cycle_stabilizer             <= dcs_q;
            o_long_pseudo_random_generator_rst  <= lrst_q;         // R9
            o_short_pseudo_random_generator_rst <= srst_q;         // R10
        end
    end

    // Undefined mode codes decode to nothing: safest is no action
    assign o_chip_run                  = is_mode(o_power_mode, `PM_RUN);        // R3
    assign o_powered_down              = is_mode(o_power_mode, `PM_POWER_DOWN); // R4
    assign o_standby                   = is_mode(o_power_mode, `PM_STANDBY);    // R4
    assign o_soft_reset                = is_mode(o_power_mode, `PM_RESET);      // R5
    assign o_continuous_wave_operation = is_mode(o_power_mode, `PM_CONT_WAVE);  // R5
    // Full power-down also leaves the gain path unpowered
    assign o_time_gain_signal_path_off = o_continuous_wave_operation || o_powered_down; // R5

    // Test register reads lowest indexed channel; none selected shows channel 0
    always @*
    begin
        rd_ch = 3'h0;
        for (k = `NUM_CHANNELS - 1; k >= 0; k = k - 1)
        begin
            if (chan_sel[k])
            begin
                rd_ch = k[2:0];
            end
        end
    end

    // Reads return staged values, not the active copy
    always @*
    begin
        rdata_d = 8'h00;
        if (is_addr(i_addr, `OFS_POWER_MODE_CONTROL))
        begin
            rdata_d = {5'h00, mode_q};                             // R6
        end
        else if (is_addr(i_addr, `OFS_CLOCK_STABILIZER_CONTROL))
        begin
            rdata_d = {7'h00, dcs_q};                              // R7
        end
        else if (is_addr(i_addr, `OFS_TEST_OUTPUT_CONTROL))
        begin
            rdata_d = {utm_q[rd_ch*2 +: 2], lrst_q, srst_q, pat_q[rd_ch*4 +: 4]};
        end
        else if (is_addr(i_addr, `OFS_STAGED_SETTINGS_UPDATE))
        begin
            rdata_d = {7'h00, commit_q};                           // R2 R17
        end
        else if (is_addr(i_addr, `OFS_DEVICE_INDEX_2))
        begin
            rdata_d = {4'h0, idx_hi_q};
        end
        else if (is_addr(i_addr, `OFS_DEVICE_INDEX_1))
        begin
            rdata_d = {4'h0, idx_lo_q};
        end
        else
        begin
            // Unmapped addresses read as zero
            rdata_d = 8'h00;
        end
    end

    // Read data holds until the next read strobe
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            o_rdata <= rdata_d;
        end
    end

endmodule // converter_mode_test_config_regs

// ===== hw/converter_mode_test_config_regs.vh
// Purpose: Offsets, fields, reset values of the converter mode/test registers
// Assumes: 8-bit registers addressed over the serial configuration port
// Notes:   Included by converter_mode_test_config_regs.v
`ifndef CONVERTER_MODE_TEST_CONFIG_REGS_VH
`define CONVERTER_MODE_TEST_CONFIG_REGS_VH

`define OFS_POWER_MODE_CONTROL       8'h08
`define OFS_CLOCK_STABILIZER_CONTROL 8'h09
`define OFS_TEST_OUTPUT_CONTROL      8'h0D
`define OFS_STAGED_SETTINGS_UPDATE   8'hFF
`define OFS_DEVICE_INDEX_2           8'h04
`define OFS_DEVICE_INDEX_1           8'h05

`define RST_POWER_MODE_CONTROL       8'h00
`define RST_CLOCK_STABILIZER_CONTROL 8'h01
`define RST_TEST_OUTPUT_CONTROL      8'h00
`define RST_STAGED_SETTINGS_UPDATE   8'h00
`define RST_DEVICE_INDEX             4'hF

`define PM_RUN                       3'h0
`define PM_POWER_DOWN                3'h1
`define PM_STANDBY                   3'h2
`define PM_RESET                     3'h3
`define PM_CONT_WAVE                 3'h4

`define TP_OFF                       4'h0
`define TP_MIDSCALE                  4'h1
`define TP_POS_FULL                  4'h2
`define TP_NEG_FULL                  4'h3
`define TP_CHECKER                   4'h4
`define TP_PRN_LONG                  4'h5
`define TP_PRN_SHORT                 4'h6
`define TP_WORD_TOGGLE               4'h7
`define TP_USER                      4'h8
`define TP_BIT_TOGGLE                4'h9
`define TP_ONE_BIT_HIGH              4'hB
`define TP_MIXED_FREQ                4'hC

`define TEST_PATTERN_LSB             0
`define TEST_PATTERN_MSB             3
`define TEST_SHORT_PRN_RST_BIT       4
`define TEST_LONG_PRN_RST_BIT        5
`define TEST_USER_MODE_LSB           6
`define TEST_USER_MODE_MSB           7

`define NUM_CHANNELS                 8

`endif

// ===== testbench/cfg_host_model.sv
// Purpose: Host of the config port, one access per queued entry
// Assumes: One-cycle strobes
// Notes:   Idle address/data invert so nothing looks held
module cfg_host_model
(
    input  wire logic  i_clk,
    output logic       o_wr,
    output logic       o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [17:0] cmds[$];
    initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
    task automatic push(input logic [17:0] c);
        cmds.push_back(c);
    endtask
    always @(posedge i_clk)
        if (cmds.size() != 0)
            {o_wr, o_rd, o_addr, o_wdata} <= cmds.pop_front();
        else
            {o_wr, o_rd, o_addr, o_wdata} <= {2'b00, ~o_addr, ~o_wdata};
endmodule // cfg_host_model

// ===== testbench/cfg_regs_asserts.sv
// Purpose: Port assertions for the mode/test registers
// Assumes: One clock, sync active-low reset
// Notes:   Commit shows two edges after the 0xFF write
module cfg_regs_asserts
(
    // Clock and reset
    input wire        i_clk,
    input wire        i_nrst,
    // Register access
    input wire        i_wr,
    input wire        i_rd,
    input wire [7:0]  i_addr,
    input wire [7:0]  i_wdata,
    input wire [7:0]  o_rdata,
    // Active settings
    input wire [2:0]  o_power_mode,
    input wire        o_chip_run,
    input wire        o_time_gain_signal_path_off,
    input wire        o_duty_cycle_stabilizer,
    input wire [31:0] o_test_pattern,
    input wire [7:0]  o_test_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire commit = i_wr && i_addr == 8'hFF && i_wdata[0];
    chk_run_decode: assert property (o_chip_run == (o_power_mode == 3'h0))
        else $error("Run decode wrong");
    chk_gain_off: assert property (
        o_time_gain_signal_path_off == (o_power_mode == 3'h1 || o_power_mode == 3'h4))
        else $error("Gain path decode wrong");
    chk_test_active: assert property (o_test_active[0] == |o_test_pattern[3:0])
        else $error("Test active wrong");
    chk_mode_commit: assert property (
        $changed(o_power_mode) || $changed(o_duty_cycle_stabilizer) |-> $past(commit, 2))
        else $error("Global change without commit");
    chk_pattern_commit: assert property ($changed(o_test_pattern) |-> $past(commit, 2))
        else $error("Pattern change without commit");
    chk_update_read: assert property (
        i_rd && i_addr == 8'hFF |=> o_rdata == {7'h00, $past(commit, 2)})
        else $error("Update read wrong");
    chk_mode_read: assert property (i_rd && i_addr == 8'h08 |=> o_rdata[7:3] == 5'h00)
        else $error("Mode upper bits set");
    chk_reset_values: assert property (
        $rose(i_nrst) |-> o_power_mode == 3'h0 && o_duty_cycle_stabilizer && o_rdata == 8'h00)
        else $error("Reset values wrong");
endmodule // cfg_regs_asserts
bind converter_mode_test_config_regs cfg_regs_asserts cfg_regs_asserts_i (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_power_mode(o_power_mode), .o_chip_run(o_chip_run),
    .o_time_gain_signal_path_off(o_time_gain_signal_path_off),
    .o_duty_cycle_stabilizer(o_duty_cycle_stabilizer), .o_test_pattern(o_test_pattern),
    .o_test_active(o_test_active));

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the mode/test registers
// Assumes: 50 MHz clock, host model drives the port
// Notes:   Read results checked against a note queue
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        rd_d = 1'b0;
    logic [7:0]  exp_q[$];
    logic [31:0] exp_pat = 32'h0;
    logic [15:0] exp_um = 16'h0;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          seed = 32'h7588AB48;
    wire         wr, rd, time_gain_signal_path, duty_cycle_stabilizer, lrst, srst;
    wire         run, pdn, sby, srm, cw;
    wire [7:0]   addr, wdata, rdata, act;
    wire [2:0]   pm;
    wire [31:0]  pat;
    wire [15:0]  um;
    always #10 i_clk = ~i_clk;
    cfg_host_model cfg_host_model_i (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata));
    converter_mode_test_config_regs converter_mode_test_config_regs_i (.i_clk(i_clk),
        .i_nrst(i_nrst), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_power_mode(pm), .o_chip_run(run), .o_powered_down(pdn), .o_standby(sby),
        .o_soft_reset(srm), .o_continuous_wave_operation(cw), .o_time_gain_signal_path_off(time_gain_signal_path),
        .o_duty_cycle_stabilizer(duty_cycle_stabilizer), .o_long_pseudo_random_generator_rst(lrst),
        .o_short_pseudo_random_generator_rst(srst), .o_test_pattern(pat),
        .o_user_test_mode(um), .o_test_active(act));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        cfg_host_model_i.push({2'b10, a, d});
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cfg_host_model_i.push({2'b01, a, 8'h00});
    endtask
    // Margin covers commit flag plus copy edge
    task automatic settle;
        while (cfg_host_model_i.cmds.size() != 0)
            @(posedge i_clk);
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    always @(posedge i_clk)
        rd_d <= rd;
    always @(negedge i_clk)
        if (rd_d === 1'b1)
            check("rdata", rdata, exp_q.pop_front());
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            error_cnt++;
            final_report();
        end
    end
    initial
    begin
        logic [7:0] idx;
        logic [7:0] v;
        logic [7:0] exp_act;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        get(8'h09, 8'h01);
        get(8'h0D, 8'h00);
        get(8'hFF, 8'h00);
        put(8'h20, 8'h5A);
        get(8'h20, 8'h00);
        for (int m = 0; m < 5; m++)
        begin
            put(8'h08, 8'hF8 | 8'(m));
            put(8'h09, {7'h7F, m[0]});
            put(8'hFF, 8'h00);
            get(8'h08, 8'(m));
            settle();
            check("mode_hold", pm, m == 0 ? 0 : m - 1);
            check("dcs_hold", duty_cycle_stabilizer, m == 0 ? 1 : (m - 1) % 2);
            put(8'hFF, 8'h01);
            get(8'hFF, 8'h01);
            get(8'hFF, 8'h00);
            settle();
            check("mode", pm, m);
            check("gain_off", time_gain_signal_path, m == 1 || m == 4);
            check("decode", {cw, srm, sby, pdn, run}, 5'h01 << m);
            check("dcs", duty_cycle_stabilizer, m % 2);
        end
        for (int k = 0; k < 12; k++)
        begin
            idx = 8'($random(seed));
            v = 8'($random(seed));
            // Codes 1010 and above 1100 are unassigned, so they are skipped
            v[3:0] = (k < 10) ? 4'(k) : 4'(k + 1);
            v[7:6] = k[1:0];
            put(8'h05, {4'h0, idx[3:0]});
            put(8'h04, {4'h0, idx[7:4]});
            put(8'h0D, v);
            settle();
            check("pattern_hold", pat, exp_pat);
            put(8'hFF, 8'h01);
            settle();
            for (int c = 0; c < 8; c++)
                if (idx[c])
                    {exp_um[2*c +: 2], exp_pat[4*c +: 4]} = {v[7:6], v[3:0]};
            check("pattern", pat, exp_pat);
            check("user_mode", um, exp_um);
            check("gen_rst", {lrst, srst}, v[5:4]);
            for (int c = 0; c < 8; c++)
                exp_act[c] = (exp_pat[4*c +: 4] != 4'h0);
            check("active", act, exp_act);
        end
        // Mid-run reset must bring every active value home, and the staged registers that are read back here
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        get(8'h05, 8'h0F);
        get(8'h04, 8'h0F);
        get(8'h0D, 8'h00);
        get(8'hFF, 8'h00);
        get(8'h09, 8'h01);
        settle();
        check("rst_mode", pm, 3'h0);
        check("rst_dcs", duty_cycle_stabilizer, 1'b1);
        check("rst_pat", pat, 32'h0);
        check("rst_um", um, 16'h0);
        check("rst_gen", {lrst, srst}, 2'h0);
        check("rst_act", act, 8'h00);
        final_report();
    end
endmodule // testbench
